//--- rtl/opnl_pkg.sv
// Purpose: shared constants for the operator panel address entry block
// Assumes: 50 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: register offsets are byte addresses of aligned words
package opnl_pkg;

  // program address counter and jump selects
  localparam int PAC_W = 18;
  localparam int JMP_W = 3;
  localparam logic [PAC_W-1:0] PAC_RESET = 18'h00000;
  localparam logic [PAC_W-1:0] PAC_ONE = 18'h00001;
  // bits that the panel may set; the top switch is not wired
  localparam logic [PAC_W-1:0] PAC_SET_MASK = 18'h1FFFF;
  localparam logic [JMP_W-1:0] JMP_RESET = 3'h0;

  // press vector layout: address bits, clear, jump select, jump release
  localparam int PRESS_CLEAR_BIT = PAC_W;
  localparam int PRESS_JSEL_LSB = PAC_W + 1;
  localparam int PRESS_JREL_LSB = PAC_W + 1 + JMP_W;
  localparam int PRESS_W = PAC_W + 1 + 2 * JMP_W;

  // bus geometry
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [AXI_DATA_W-1:0] WORD_ZERO = 32'h00000000;

  // register offsets
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [AXI_ADDR_W-1:0] REG_COUNTER = 12'h004;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 12'h008;

  // control register fields (maintenance panel settings)
  localparam int CTRL_W = 5;
  localparam int CTRL_MAINT_BIT = 0;
  localparam int CTRL_DAYCLK_BIT = 1;
  localparam int CTRL_ETIME_BIT = 2;
  localparam int CTRL_GUARD_BIT = 3;
  localparam int CTRL_LOCKOUT_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // status register fields
  localparam int STAT_JUMP_LSB = 0;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_LAMP_LSB = 4;

endpackage

//--- rtl/opnl_press_detect.sv
// Purpose: synchronise momentary switches and emit one pulse per press
// Assumes: switch levels are high while held, bounce already filtered
// Notes: pulse appears three edges after the switch rises
`timescale 1ns/1ns
`default_nettype none
module opnl_press_detect import opnl_pkg::*; #(
  parameter int W = PRESS_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] switch_level,
  output logic [W-1:0] press
);

  typedef struct packed {
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] prev;
    logic [W-1:0] pulse;
  } opnl_det_t;

  opnl_det_t state;
  opnl_det_t next_state;

  // two-stage sync, then rising edge of the second stage
  always_comb begin
    next_state = state;
    next_state.sync1 = switch_level;
    next_state.sync2 = state.sync1;
    next_state.prev = state.sync2;
    next_state.pulse = state.sync2 & ~state.prev;
  end

  // register the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign press = state.pulse;

endmodule
`default_nettype wire

//--- rtl/opnl_panel.sv
// Purpose: operator panel logic for the program address counter and the
//   disable and mode lamps, with an AXI4-Lite register slave
// Assumes: processor control drives run state and counter updates
// Notes: maintenance panel settings are held in the control register
//   ctrl word: bit 0 maintenance disable, bit 1 day clock disable,
//   bit 2 elapsed timer disable, bit 3 guard, bit 4 lockout
//   counter word reads the program address counter, writes are ignored
//   status word: jump selects, live run flag, lamp copies of ctrl
//   a ctrl write needs the low byte strobe, otherwise it is dropped
//   unmapped offsets answer with an error and read as zero
//   a switch press lands on the counter four edges after it rises
//   address and clear presses made while running or under lockout are lost, not queued
//   the top address switch is not wired and never sets its bit
//   jump selects and releases act at all times; release wins a tie
//   counter lamps go dark from the first edge that sees the run flag
`timescale 1ns/1ns
`default_nettype none
module opnl_panel import opnl_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address channel
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data channel
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address channel
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data channel
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // operator switches, high while held
  input wire logic [PAC_W-1:0] address_bit_switches,
  input wire logic counter_clear_switch,
  input wire logic [JMP_W-1:0] jump_select_switches,
  input wire logic [JMP_W-1:0] jump_release_switches,
  // processor control section
  input wire logic cpu_running,
  input wire logic cpu_pc_load,
  input wire logic [PAC_W-1:0] cpu_pc_load_value,
  input wire logic cpu_pc_step,
  output logic [PAC_W-1:0] program_address,
  // panel lamps
  output logic [PAC_W-1:0] counter_lamps,
  output logic [JMP_W-1:0] jump_select_lamps,
  output logic maintenance_disable_lamp,
  output logic day_clock_disable_lamp,
  output logic elapsed_timer_disable_lamp,
  output logic guard_lamp,
  output logic lockout_lamp
);

  typedef struct packed {
    // write channel
    logic awready;
    logic wready;
    logic aw_have;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [AXI_DATA_W-1:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    // read channel
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [AXI_DATA_W-1:0] rdata;
    // block state
    logic [CTRL_W-1:0] ctrl;
    logic [PAC_W-1:0] counter;
    logic [JMP_W-1:0] jumps;
    logic [PAC_W-1:0] lamps;
    logic [CTRL_W-1:0] ind;
  } opnl_state_t;

  localparam opnl_state_t STATE_RESET = '{
    awready: 1'b0,
    wready: 1'b0,
    aw_have: 1'b0,
    aw_addr: '0,
    w_have: 1'b0,
    w_data: WORD_ZERO,
    w_strb0: 1'b0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rresp: RESP_OKAY,
    rdata: WORD_ZERO,
    ctrl: CTRL_RESET,
    counter: PAC_RESET,
    jumps: JMP_RESET,
    lamps: PAC_RESET,
    ind: CTRL_RESET
  };

  opnl_state_t state;
  opnl_state_t next_state;
  logic [PRESS_W-1:0] press;
  logic [PRESS_W-1:0] switch_level;

  // true when the offset names a mapped register
  function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] a);
    case (a)
      REG_CTRL, REG_COUNTER, REG_STATUS: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  // a write channel takes a beat only when nothing is held or answered
  function automatic logic can_take(input logic have, input logic busy);
    can_take = !have && !busy;
  endfunction

  // processor update of the counter: a load wins over a step
  function automatic logic [PAC_W-1:0] cpu_next(
    input logic [PAC_W-1:0] cur,
    input logic load,
    input logic [PAC_W-1:0] value,
    input logic step
  );
    logic [PAC_W-1:0] n;
    n = cur;
    if (load) begin
      n = value;
    end else if (step) begin
      n = cur + PAC_ONE;
    end
    cpu_next = n;
  endfunction

  // read word for a register offset
  function automatic logic [AXI_DATA_W-1:0] read_word(
    input logic [AXI_ADDR_W-1:0] a,
    input opnl_state_t s,
    input logic run
  );
    logic [AXI_DATA_W-1:0] w;
    w = WORD_ZERO;
    case (a)
      REG_CTRL: begin
        w = AXI_DATA_W'(s.ctrl);
      end
      REG_COUNTER: begin
        w = AXI_DATA_W'(s.counter);
      end
      REG_STATUS: begin
        // jump selects, live run flag, lamp copies
        w[STAT_JUMP_LSB +: JMP_W] = s.jumps;
        w[STAT_RUN_BIT] = run;
        w[STAT_LAMP_LSB +: CTRL_W] = s.ind;
      end
      default: begin
        w = WORD_ZERO;
      end
    endcase
    read_word = w;
  endfunction

  // gather the switches into one press vector
  assign switch_level = {jump_release_switches, jump_select_switches,
                         counter_clear_switch, address_bit_switches};

  // one pulse per press, after synchronisation
  opnl_press_detect #(
    .W(PRESS_W)
  ) u_press (
    .aclk(aclk),
    .aresetn(aresetn),
    .switch_level(switch_level),
    .press(press)
  );

  // next state: bus slave, counter, jumps and lamps
  always_comb begin
    logic lockout;
    logic [PAC_W-1:0] set_bits;
    logic [JMP_W-1:0] jsel;
    logic [JMP_W-1:0] jrel;
    next_state = state;
    // sort the press pulses by kind
    lockout = state.ctrl[CTRL_LOCKOUT_BIT];
    set_bits = press[PAC_W-1:0] & PAC_SET_MASK;
    jsel = press[PRESS_JSEL_LSB +: JMP_W];
    jrel = press[PRESS_JREL_LSB +: JMP_W];

    // capture write address and data in either order
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_have = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_have = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb0 = s_axi_wstrb[0];
    end

    // response retires first, then a held pair performs its write
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (state.aw_have && state.w_have && !state.bvalid) begin
      next_state.aw_have = 1'b0;
      next_state.w_have = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = is_mapped(state.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (state.aw_addr == REG_CTRL && state.w_strb0) begin
        next_state.ctrl = state.w_data[CTRL_W-1:0];
      end
    end
    // readies drop while a beat is held or the answer waits
    next_state.awready = can_take(next_state.aw_have, next_state.bvalid);
    next_state.wready = can_take(next_state.w_have, next_state.bvalid);

    // read: one outstanding answer at a time
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state.arready) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = read_word(s_axi_araddr, state, cpu_running);
      next_state.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // a new read waits until the answer is taken
    next_state.arready = !next_state.rvalid;

    // program address counter
    if (cpu_running) begin
      // the processor keeps the next instruction address here
      next_state.counter = cpu_next(state.counter, cpu_pc_load,
        cpu_pc_load_value, cpu_pc_step);
      // panel presses have no effect while running
    end else if (!lockout) begin
      if (press[PRESS_CLEAR_BIT]) begin
        next_state.counter = PAC_RESET;
        next_state.counter = PAC_RESET | set_bits;
      end else begin
        next_state.counter = state.counter | set_bits;
      end
    end

    // jump selects stay live even under lockout and while running
    next_state.jumps = (state.jumps | jsel) & ~jrel;

    // counter lamps dark while a program runs
    next_state.lamps = cpu_running ? PAC_RESET : next_state.counter;

    // disable and mode lamps follow the maintenance settings
    next_state.ind[CTRL_MAINT_BIT] = next_state.ctrl[CTRL_MAINT_BIT];
    next_state.ind[CTRL_DAYCLK_BIT] = next_state.ctrl[CTRL_DAYCLK_BIT];
    next_state.ind[CTRL_ETIME_BIT] = next_state.ctrl[CTRL_ETIME_BIT];
    next_state.ind[CTRL_GUARD_BIT] = next_state.ctrl[CTRL_GUARD_BIT];
    next_state.ind[CTRL_LOCKOUT_BIT] =
      next_state.ctrl[CTRL_LOCKOUT_BIT];
  end

  // register the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // write channel outputs straight from flops
  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;

  // read channel outputs straight from flops
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rresp = state.rresp;
  assign s_axi_rdata = state.rdata;

  // counter to the processor, counter and jump lamps, from flops
  assign program_address = state.counter;
  assign counter_lamps = state.lamps;
  assign jump_select_lamps = state.jumps;

  // disable and mode lamps straight from flops
  assign maintenance_disable_lamp = state.ind[CTRL_MAINT_BIT];
  assign day_clock_disable_lamp = state.ind[CTRL_DAYCLK_BIT];
  assign elapsed_timer_disable_lamp = state.ind[CTRL_ETIME_BIT];
  assign guard_lamp = state.ind[CTRL_GUARD_BIT];
  assign lockout_lamp = state.ind[CTRL_LOCKOUT_BIT];

endmodule
`default_nettype wire

//--- tb/opnl_panel_chk.sv
// Purpose: port checks for the operator panel
// Assumes: one clock, synchronous active low reset
// Notes: bound to every panel instance
`timescale 1ns/1ns
`default_nettype none
module opnl_panel_chk import opnl_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PAC_W-1:0] address_bit_switches,
  input wire logic counter_clear_switch,
  input wire logic cpu_running,
  input wire logic cpu_pc_load,
  input wire logic [PAC_W-1:0] cpu_pc_load_value,
  input wire logic cpu_pc_step,
  input wire logic [PAC_W-1:0] program_address,
  input wire logic [PAC_W-1:0] counter_lamps,
  input wire logic lockout_lamp
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // lamps follow the counter, dark while running
  lamps_show_a: assert property (
    !$past(cpu_running) && !$past(cpu_running, 2)
    |-> counter_lamps == program_address) else $error("lamps off counter");
  lamps_dark_a: assert property (
    $past(cpu_running) && $past(cpu_running, 2)
    |-> counter_lamps == PAC_RESET) else $error("lamps lit running");
  // processor owns the counter while running
  pc_step_a: assert property (
    cpu_running && cpu_pc_step && !cpu_pc_load
    |=> program_address == $past(program_address) + PAC_ONE)
    else $error("no step");
  pc_load_a: assert property (
    cpu_running && cpu_pc_load
    |=> program_address == $past(cpu_pc_load_value)) else $error("no load");
  run_hold_a: assert property (
    (cpu_running && !cpu_pc_load && !cpu_pc_step)[*3]
    |=> $stable(program_address)) else $error("moved while running");
  // panel entry
  clear_all_a: assert property (
    $rose(counter_clear_switch) ##0 (address_bit_switches == PAC_RESET
    && !cpu_running && !lockout_lamp)[*4]
    |=> program_address == PAC_RESET) else $error("clear incomplete");
  bits_keep_a: assert property (
    (!counter_clear_switch && !cpu_running)[*5]
    |=> (program_address | $past(program_address)) == program_address)
    else $error("bit lost");
  lockout_hold_a: assert property (
    (lockout_lamp && !cpu_running)[*5] |=> $stable(program_address))
    else $error("moved under lockout");
  // main scenarios reached
  cover property ($rose(counter_clear_switch) && !cpu_running);
  cover property (lockout_lamp && $rose(address_bit_switches[2]));
  cover property (cpu_running && cpu_pc_step);
endmodule
bind opnl_panel opnl_panel_chk chk (.aclk, .aresetn, .address_bit_switches,
  .counter_clear_switch, .cpu_running, .cpu_pc_load, .cpu_pc_load_value,
  .cpu_pc_step, .program_address, .counter_lamps, .lockout_lamp);
`default_nettype wire

//--- tb/opnl_operator.sv
// Purpose: operator pressing panel switches
// Assumes: one press at a time, vector in press layout
// Notes: released switches spring back low
`timescale 1ns/1ns
`default_nettype none
module opnl_operator import opnl_pkg::*; (
  input wire logic aclk,
  output logic [PAC_W-1:0] address_bit_switches,
  output logic counter_clear_switch,
  output logic [JMP_W-1:0] jump_select_switches,
  output logic [JMP_W-1:0] jump_release_switches
);
  logic [PRESS_W-1:0] sw = 25'h0000000;
  // switch levels from the held vector
  assign {jump_release_switches, jump_select_switches, counter_clear_switch,
    address_bit_switches} = sw;
  // hold for h cycles, release, wait until the action lands
  task automatic press(input logic [PRESS_W-1:0] v, input int h);
    @(posedge aclk);
    sw <= v;
    repeat (h) @(posedge aclk);
    sw <= 25'h0000000;
    repeat (6) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the operator panel
// Assumes: AXI4-Lite master tasks, operator model drives switches
// Notes: expected values from package constants
`timescale 1ns/1ns
`default_nettype none
module tb import opnl_pkg::*;;
  logic aclk = 1'h0, aresetn = 1'h0, cpu_running = 1'h0;
  logic cpu_pc_load = 1'h0, cpu_pc_step = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [AXI_DATA_W-1:0] s_axi_wdata = WORD_ZERO, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [PAC_W-1:0] cpu_pc_load_value = PAC_RESET;
  logic [PAC_W-1:0] program_address, counter_lamps;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, guard_lamp, lockout_lamp, maintenance_disable_lamp;
  logic day_clock_disable_lamp, elapsed_timer_disable_lamp;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [JMP_W-1:0] jump_select_lamps;
  wire [PAC_W-1:0] address_bit_switches;
  wire counter_clear_switch;
  wire [JMP_W-1:0] jump_select_switches, jump_release_switches;
  wire [CTRL_W-1:0] lamps = {lockout_lamp, guard_lamp,
    elapsed_timer_disable_lamp, day_clock_disable_lamp,
    maintenance_disable_lamp};
  int mismatches = 0;
  int check_count = 0;
  opnl_panel uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .address_bit_switches, .counter_clear_switch, .jump_select_switches,
    .jump_release_switches, .cpu_running, .cpu_pc_load, .cpu_pc_load_value,
    .cpu_pc_step, .program_address, .counter_lamps, .jump_select_lamps,
    .maintenance_disable_lamp, .day_clock_disable_lamp,
    .elapsed_timer_disable_lamp, .guard_lamp, .lockout_lamp);
  opnl_operator op (.aclk, .address_bit_switches, .counter_clear_switch,
    .jump_select_switches, .jump_release_switches);
  // free running clock
  initial begin
    forever #10 aclk = ~aclk;
  end
  // report and stop
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one write, each channel held until taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] r);
    logic ta, tw, tr;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready === 1'h1;
      tw = s_axi_wvalid && s_axi_wready === 1'h1;
      tr = s_axi_bvalid === 1'h1;
      if (tr) chk("bresp", r, s_axi_bresp);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) begin
        s_axi_bready <= 1'h0;
        return;
      end
    end
    mismatches++;
    wrap_up;
  endtask
  // one read, compare data and response
  task automatic axr(input logic [11:0] a, input logic [31:0] e,
      input logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready === 1'h1;
      tr = s_axi_rvalid === 1'h1;
      if (tr) chk("rdata", e, s_axi_rdata);
      if (tr) chk("rresp", r, s_axi_rresp);
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) begin
        s_axi_rready <= 1'h0;
        return;
      end
    end
    mismatches++;
    wrap_up;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    axr(REG_COUNTER, WORD_ZERO, RESP_OKAY);
    for (int i = 0; i < CTRL_W; i++) begin
      axw(REG_CTRL, 32'h1 << i, 4'hF, RESP_OKAY);
      chk("lamps", 32'h1 << i, lamps);
      axr(REG_STATUS, 32'h10 << i, RESP_OKAY);
    end
    op.press({3'h0, 3'h2, 1'h0, 18'h00004}, 2);
    chk("counter", PAC_RESET, program_address);
    chk("jumps", 3'h2, jump_select_lamps);
    axr(REG_STATUS, 32'h102, RESP_OKAY);
    op.press({3'h6, 3'h5, 1'h0, 18'h00000}, 1);
    chk("jumps", 3'h1, jump_select_lamps);
    axw(REG_CTRL, 32'h1F, 4'h0, RESP_OKAY);
    axw(REG_COUNTER, 32'h3FFFF, 4'hF, RESP_OKAY);
    axw(12'h00C, 32'h1F, 4'hF, RESP_SLVERR);
    axr(12'h00C, WORD_ZERO, RESP_SLVERR);
    axr(REG_CTRL, 32'h10, RESP_OKAY);
    axw(REG_CTRL, WORD_ZERO, 4'hF, RESP_OKAY);
    op.press({3'h0, 3'h0, 1'h0, 18'h20009}, 1);
    chk("counter", 32'h00009, program_address);
    op.press({3'h0, 3'h0, 1'h0, 18'h00010}, 5);
    chk("lamps", 32'h00019, counter_lamps);
    op.press({3'h0, 3'h0, 1'h1, 18'h00001}, 1);
    chk("counter", 32'h00001, program_address);
    @(posedge aclk);
    cpu_running <= 1'h1;
    cpu_pc_load <= 1'h1;
    cpu_pc_load_value <= 18'h3FFFE;
    @(posedge aclk);
    cpu_pc_load <= 1'h0;
    cpu_pc_step <= 1'h1;
    repeat (3) @(posedge aclk);
    cpu_pc_step <= 1'h0;
    op.press({3'h0, 3'h0, 1'h1, 18'h00002}, 1);
    chk("counter", 32'h00001, program_address);
    chk("lamps", WORD_ZERO, counter_lamps);
    axr(REG_STATUS, 32'h9, RESP_OKAY);
    cpu_running <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("lamps", 32'h00001, counter_lamps);
    op.press({3'h0, 3'h0, 1'h1, 18'h00000}, 1);
    chk("counter", PAC_RESET, program_address);
    wrap_up;
  end
endmodule
`default_nettype wire
